// >>> rtl/csf_flags_top.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Start flag high for first scan only.
// - One second wave unless hold set.
// - Tenth second wave always runs.
// - Hundredth second wave always runs.
// - Altered preset sets preset flag.
// - Download or preset clear drops flag.
// - Run flag high while program executes.
// - Timer interrupt flag follows its enable.
// - Compare sets one of three results.
// - Catch edge captures level, once per scan.
module csf_flags_top #(
	parameter int unsigned HALF_1S = csf_pkg::HALF_1S_CYC, // One second half period.
	parameter int unsigned HALF_100MS = csf_pkg::HALF_100MS_CYC, // Tenth half period.
	parameter int unsigned HALF_10MS = csf_pkg::HALF_10MS_CYC, // Hundredth half period.
	parameter int CMP_W = 16 // Width of compare operands.
) (
	input wire logic clk_i, // Core clock, 100 MHz.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic wb_cyc_i, // Bus cycle.
	input wire logic wb_stb_i, // Bus strobe.
	input wire logic wb_we_i, // Bus write enable.
	input wire logic [csf_pkg::ADR_W-1:0] wb_adr_i, // Byte address.
	input wire logic [3:0] wb_sel_i, // Byte selects.
	input wire logic [31:0] wb_dat_i, // Write data.
	output logic [31:0] wb_dat_o, // Read data.
	output logic wb_ack_o, // Bus acknowledge.
	input wire logic scan_end_i, // One-cycle pulse at the end of each scan.
	input wire logic preset_alter_i, // A timer or counter preset was altered.
	input wire logic preset_clear_i, // Altered presets were cleared.
	input wire logic download_i, // A new user program was downloaded.
	input wire logic cmp_valid_i, // A magnitude compare ran this cycle.
	input wire logic [CMP_W-1:0] cmp_a_i, // First compare operand.
	input wire logic [CMP_W-1:0] cmp_b_i, // Second compare operand.
	input wire logic [1:0] catch_i, // Catch inputs, group four in bit 0.
	output csf_pkg::csf_flags_t flags_o, // Flag bank.
	output logic irq_o // Level interrupt.
);
	import csf_pkg::*;

	// ----------------------------------------------------------------------
	// State.
	// ----------------------------------------------------------------------

	// All state of the bank except the wave generators in one record.
	typedef struct packed {
		csf_flags_t flags;
		csf_phase_t phase;
		logic [CTRL_W-1:0] ctrl;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic [1:0] catch_prev;
		logic [1:0] catch_lock;
		logic ack;
		logic [31:0] dat;
		logic irq;
	} csf_state_t;

	csf_state_t q_r; // Registered state.
	csf_state_t q_nxt; // Next state.
	logic [2:0] wave; // Outputs of the three wave generators.

	// Selects a register by its byte offset.
	function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [7:0] ofs);
		hit = (adr[ADR_W-1:2] == ofs[ADR_W-1:2]);
	endfunction

	// ----------------------------------------------------------------------
	// Wave generators.
	// ----------------------------------------------------------------------

	// Half periods of the waves, one second first.
	localparam int unsigned HALF_TAB [3] = '{HALF_1S, HALF_100MS, HALF_10MS};

	// Only the one second wave obeys the hold control; none obeys run.
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_wave
			csf_pulse_gen #(
				.HALF_CYC(HALF_TAB[g])
			) u_wave (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.hold_i((g == 0) ? q_r.ctrl[CTRL_HOLD_BIT] : 1'b0),
				.pulse_o(wave[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------------
	// Next state.
	// ----------------------------------------------------------------------

	// Flag logic, catch capture, interrupt and bus slave.
	always_comb begin
		logic req;
		logic wr;
		logic [IRQ_W-1:0] ev;
		logic [IRQ_W-1:0] w1c;
		logic [1:0] edg;
		req = 1'b0;
		wr = 1'b0;
		ev = '0;
		w1c = '0;
		edg = '0;
		q_nxt = q_r;

		q_nxt.flags.one_second_pulse = wave[0];
		q_nxt.flags.tenth_second_pulse = wave[1];
		q_nxt.flags.hundredth_second_pulse = wave[2];

		q_nxt.flags.run_indicator = q_r.ctrl[CTRL_RUN_BIT];
		q_nxt.flags.timer_irq_enabled_flag = q_r.ctrl[CTRL_TIRQ_BIT];

		unique case (q_r.phase)
			CSF_IDLE: begin
				// Execution start opens the first scan.
				if (q_r.ctrl[CTRL_RUN_BIT]) begin
					q_nxt.phase = CSF_FIRST;
					q_nxt.flags.start_scan_pulse = 1'b1;
					ev[IRQ_START_BIT] = 1'b1;
				end
			end
			CSF_FIRST: begin
				// The first scan ends at its scan boundary.
				if (!q_r.ctrl[CTRL_RUN_BIT]) begin
					q_nxt.phase = CSF_IDLE;
					q_nxt.flags.start_scan_pulse = 1'b0;
				end else if (scan_end_i) begin
					q_nxt.phase = CSF_RUN;
					q_nxt.flags.start_scan_pulse = 1'b0;
				end
			end
			CSF_RUN: begin
				// Stopping rearms the pulse for the next start.
				if (!q_r.ctrl[CTRL_RUN_BIT]) begin
					q_nxt.phase = CSF_IDLE;
				end
			end
			default: begin
				// An illegal code returns to idle.
				q_nxt.phase = CSF_IDLE;
				q_nxt.flags.start_scan_pulse = 1'b0;
			end
		endcase

		if (download_i || preset_clear_i) begin
			q_nxt.flags.preset_changed_flag = 1'b0;
		end
		if (preset_alter_i) begin
			q_nxt.flags.preset_changed_flag = 1'b1;
			ev[IRQ_PRESET_BIT] = 1'b1;
		end

		if (cmp_valid_i) begin
			q_nxt.flags.cmp_greater_flag = (cmp_a_i > cmp_b_i);
			q_nxt.flags.cmp_equal_flag = (cmp_a_i == cmp_b_i);
			q_nxt.flags.cmp_less_flag = (cmp_a_i < cmp_b_i);
			ev[IRQ_CMP_BIT] = 1'b1;
		end

		q_nxt.catch_prev = catch_i;
		// An edge in the boundary cycle still belongs to the closing scan.
		edg = (catch_i ^ q_r.catch_prev) & ~q_r.catch_lock;
		for (int i = 0; i < 2; i++) begin
			if (edg[i]) begin
				ev[IRQ_CATCH_BIT] = 1'b1;
			end
		end
		if (edg[0]) begin
			q_nxt.flags.catch_status_group_four = catch_i[0];
		end
		if (edg[1]) begin
			q_nxt.flags.catch_status_group_five = catch_i[1];
		end
		// Locks open again at each scan boundary.
		q_nxt.catch_lock = scan_end_i ? 2'b00 : (q_r.catch_lock | edg);

		// Bus: answer one cycle after the request, drop after one cycle.
		req = wb_cyc_i && wb_stb_i;
		q_nxt.ack = req && !q_r.ack;
		wr = req && q_r.ack && wb_we_i && wb_sel_i[0];
		if (req && !q_r.ack) begin
			// Read data is latched together with the acknowledge.
			q_nxt.dat = 32'h0000_0000;
			if (hit(wb_adr_i, OFS_FLAGS)) begin
				q_nxt.dat[$bits(csf_flags_t)-1:0] = q_r.flags;
			end else if (hit(wb_adr_i, OFS_CTRL)) begin
				q_nxt.dat[CTRL_W-1:0] = q_r.ctrl;
			end else if (hit(wb_adr_i, OFS_IRQ_STAT)) begin
				q_nxt.dat[IRQ_W-1:0] = q_r.irq_stat;
			end else if (hit(wb_adr_i, OFS_IRQ_MASK)) begin
				q_nxt.dat[IRQ_W-1:0] = q_r.irq_mask;
			end
		end
		// Writes land on the edge that the master samples the acknowledge.
		// flag bank ignores writes
		if (wr) begin
			if (hit(wb_adr_i, OFS_CTRL)) begin
				q_nxt.ctrl = wb_dat_i[CTRL_W-1:0];
			end else if (hit(wb_adr_i, OFS_IRQ_MASK)) begin
				q_nxt.irq_mask = wb_dat_i[IRQ_W-1:0];
			end else if (hit(wb_adr_i, OFS_IRQ_STAT)) begin
				w1c = wb_dat_i[IRQ_W-1:0];
			end
		end

		// Sticky status: a new event beats a clear in the same cycle.
		q_nxt.irq_stat = (q_r.irq_stat & ~w1c) | ev;
		// Taken from the next state so that the line rises with its status bit.
		q_nxt.irq = |(q_nxt.irq_stat & q_nxt.irq_mask);
	end

	// Register the state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_r.flags <= FLAGS_RESET;
			q_r.phase <= CSF_IDLE;
			q_r.ctrl <= CTRL_RESET;
			q_r.irq_stat <= IRQ_RESET;
			q_r.irq_mask <= IRQ_RESET;
			// Track the pins through reset so that a level held high gives no false edge.
			q_r.catch_prev <= catch_i;
			q_r.catch_lock <= 2'b00;
			q_r.ack <= 1'b0;
			q_r.dat <= 32'h0000_0000;
			q_r.irq <= 1'b0;
		end else begin
			q_r <= q_nxt;
		end
	end

	// ----------------------------------------------------------------------
	// Outputs.
	// ----------------------------------------------------------------------

	// Every output is a flip-flop of the state record.
	assign flags_o = q_r.flags;
	assign wb_ack_o = q_r.ack;
	assign wb_dat_o = q_r.dat;
	assign irq_o = q_r.irq;

	// ----------------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------------

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Execution begins while idle.
	sequence s_run_begins;
		q_r.phase == CSF_IDLE && q_r.ctrl[CTRL_RUN_BIT];
	endsequence

	// The first scan closes.
	sequence s_first_scan_ends;
		q_r.flags.start_scan_pulse && q_r.ctrl[CTRL_RUN_BIT] && scan_end_i;
	endsequence

	chk_start_rises: assert property (s_run_begins |=> q_r.flags.start_scan_pulse)
		else $error("Start flag did not rise when execution began.");

	chk_start_one_scan: assert property (s_first_scan_ends |=>
		!q_r.flags.start_scan_pulse [*2])
		else $error("Start flag outlived the first scan.");

	chk_second_hold: assert property (q_r.ctrl[CTRL_HOLD_BIT] [*3] |->
		!q_r.flags.one_second_pulse)
		else $error("One second wave ran while held.");

	chk_preset_set: assert property (preset_alter_i |=> q_r.flags.preset_changed_flag)
		else $error("Preset flag missed an alteration.");

	chk_preset_clear: assert property ((download_i || preset_clear_i) && !preset_alter_i
		|=> !q_r.flags.preset_changed_flag)
		else $error("Preset flag survived a download or clear.");

	chk_run_follow: assert property (q_r.flags.run_indicator == $past(q_r.ctrl[CTRL_RUN_BIT]))
		else $error("Run flag does not follow execution.");

	chk_tirq_follow: assert property ($changed(q_r.ctrl[CTRL_TIRQ_BIT]) |=>
		q_r.flags.timer_irq_enabled_flag == $past(q_r.ctrl[CTRL_TIRQ_BIT]))
		else $error("Timer interrupt flag does not follow its enable.");

	chk_cmp_result: assert property (cmp_valid_i |=>
		$onehot({q_r.flags.cmp_greater_flag, q_r.flags.cmp_equal_flag, q_r.flags.cmp_less_flag})
		&& (q_r.flags.cmp_greater_flag == ($past(cmp_a_i) > $past(cmp_b_i))))
		else $error("Compare result is not the one expected.");

	chk_catch_capture: assert property ((catch_i[0] != q_r.catch_prev[0]) && !q_r.catch_lock[0]
		|=> q_r.flags.catch_status_group_four == $past(catch_i[0]))
		else $error("Catch flag missed an edge.");

	chk_catch_once: assert property (q_r.catch_lock[1] && !scan_end_i
		|=> $stable(q_r.flags.catch_status_group_five))
		else $error("Catch flag took a second edge in one scan.");

	// The start flag only stands in the first scan.
	chk_start_in_first: assert property (q_r.flags.start_scan_pulse
		|-> q_r.phase == CSF_FIRST)
		else $error("Start flag set outside the first scan.");

	// Stopping the program drops the start flag at once.
	chk_start_stop: assert property (!q_r.ctrl[CTRL_RUN_BIT]
		|=> !q_r.flags.start_scan_pulse)
		else $error("Start flag stayed up after the program stopped.");

	// Compare flags keep the last result between compares.
	chk_cmp_keep: assert property (!cmp_valid_i |=>
		$stable(q_r.flags.cmp_greater_flag) && $stable(q_r.flags.cmp_equal_flag)
		&& $stable(q_r.flags.cmp_less_flag))
		else $error("Compare result changed without a compare.");

	// The preset flag moves only when one of its causes is present.
	chk_preset_keep: assert property (!preset_alter_i && !preset_clear_i
		&& !download_i |=> $stable(q_r.flags.preset_changed_flag))
		else $error("Preset flag changed without a cause.");

	// Every scan boundary opens both catch locks.
	chk_catch_unlock: assert property (scan_end_i |=> q_r.catch_lock == 2'b00)
		else $error("Catch lock survived a scan boundary.");

	chk_reset_clear: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i |=> (q_r.flags == FLAGS_RESET) && !irq_o && !wb_ack_o)
		else $error("Reset left a flag or output set.");

endmodule // csf_flags_top
`default_nettype wire

// >>> rtl/csf_pkg.sv
// ----------------------------------------------------------------------
// Constants and types shared by the system flag bank.
// ----------------------------------------------------------------------
package csf_pkg;

	// ----------------------------------------------------------------------
	// Time base.
	// ----------------------------------------------------------------------
	// Core clock rate in hertz.
	localparam int unsigned CLK_HZ = 100_000_000;
	// Cycles in one millisecond.
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
	// Half periods of the three square waves, in milliseconds.
	localparam int unsigned HALF_1S_MS = 500;
	localparam int unsigned HALF_100MS_MS = 50;
	localparam int unsigned HALF_10MS_MS = 5;
	// Half periods converted to clock cycles.
	localparam int unsigned HALF_1S_CYC = HALF_1S_MS * CYC_PER_MS;
	localparam int unsigned HALF_100MS_CYC = HALF_100MS_MS * CYC_PER_MS;
	localparam int unsigned HALF_10MS_CYC = HALF_10MS_MS * CYC_PER_MS;

	// ----------------------------------------------------------------------
	// Register bus layout.
	// ----------------------------------------------------------------------
	// Width of the byte address seen by the block.
	localparam int ADR_W = 8;
	// Byte offsets of the registers.
	localparam logic [7:0] OFS_FLAGS = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
	// Control register fields and reset value.
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_HOLD_BIT = 1;
	localparam int CTRL_TIRQ_BIT = 2;
	localparam int CTRL_W = 3;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	// Interrupt status and mask fields and reset values.
	localparam int IRQ_START_BIT = 0;
	localparam int IRQ_CATCH_BIT = 1;
	localparam int IRQ_PRESET_BIT = 2;
	localparam int IRQ_CMP_BIT = 3;
	localparam int IRQ_W = 4;
	localparam logic [3:0] IRQ_RESET = 4'h0;

	// Flag bank as software and the outputs see it, bit 0 last.
	typedef struct packed {
		logic catch_status_group_five;
		logic catch_status_group_four;
		logic cmp_less_flag;
		logic cmp_equal_flag;
		logic cmp_greater_flag;
		logic timer_irq_enabled_flag;
		logic run_indicator;
		logic preset_changed_flag;
		logic hundredth_second_pulse;
		logic tenth_second_pulse;
		logic one_second_pulse;
		logic start_scan_pulse;
	} csf_flags_t;

	// Value of the whole bank after reset.
	localparam csf_flags_t FLAGS_RESET = csf_flags_t'(12'h000);

	// Execution phase, Gray coded along idle, first scan, running.
	typedef enum logic [1:0] {
		CSF_IDLE = 2'b00,
		CSF_FIRST = 2'b01,
		CSF_RUN = 2'b11
	} csf_phase_t;

endpackage : csf_pkg

// >>> rtl/csf_pulse_gen.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Square wave of equal duty with a settable half period.
// ----------------------------------------------------------------------
module csf_pulse_gen #(
	parameter int unsigned HALF_CYC = 16 // Cycles per half period.
) (
	input wire logic clk_i, // Core clock.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic hold_i, // Holds the wave low and restarts it.
	output logic pulse_o // Square wave output.
);
	import csf_pkg::*;

	// Counter width that reaches the half period.
	localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
	// Last count of a half period.
	localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

	// All state of the generator.
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic pulse;
	} csf_pg_state_t;

	csf_pg_state_t q_r; // Registered state.
	csf_pg_state_t q_nxt; // Next state.

	// Count the half period and flip the wave at its end.
	always_comb begin
		q_nxt = q_r;
		if (hold_i) begin
			// Held waves stay low and restart from a fresh half period.
			q_nxt.cnt = '0;
			q_nxt.pulse = 1'b0;
		end else if (q_r.cnt == LAST) begin
			q_nxt.cnt = '0;
			q_nxt.pulse = ~q_r.pulse;
		end else begin
			q_nxt.cnt = q_r.cnt + CW'(1);
		end
	end

	// Register the state.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign pulse_o = q_r.pulse;

	// Each edge of the wave not forced by hold ends a full half period.
	chk_pulse_half_period: assert property (@(posedge clk_i) disable iff (rst_i)
		(!hold_i && $changed(q_r.pulse)) |-> ($past(q_r.cnt) == LAST || $past(hold_i)))
		else $error("Pulse toggled before its half period ended.");

endmodule // csf_pulse_gen
`default_nettype wire

// >>> tb/tb_controller_system_flags.sv
`timescale 1ns/100ps
`default_nettype none
// Compares one value with its expectation and counts the outcome.
`define CHK(nm, ex, sn) begin checks_done++; if ((sn) !== (ex)) begin err_count++; $display("[FAIL] %s expected %h seen %h", nm, ex, sn); end end

module tb_controller_system_flags;
	import csf_pkg::*;
	// ----------
	// Bench signals.
	// ----------
	localparam int unsigned H1 = 40; // Shortened one second half period.
	localparam int unsigned H2 = 8; // Shortened tenth half period.
	localparam int unsigned H3 = 4; // Shortened hundredth half period.
	localparam logic [11:0] EV_MASK = 12'hf90; // Flags that the event model tracks.
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00; // Bus address.
	logic [3:0] wb_sel_i = 4'h0; // Bus byte selects.
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q; // Bus data and last read word.
	logic wb_ack_o, irq_o, scan_end_i = 1'b0, preset_alter_i = 1'b0, preset_clear_i = 1'b0;
	logic download_i = 1'b0, cmp_valid_i = 1'b0, hold_m = 1'b0, chk_on = 1'b0;
	logic [15:0] cmp_a_i = 16'h0, cmp_b_i = 16'h0; // Compare operands.
	logic [1:0] catch_i = 2'h0, pc, lk; // Catch inputs, model history and locks.
	logic [11:0] m; // Model of the event driven flags.
	logic [2:0] prv, ok; // Last wave levels and valid period marks.
	int cnt [3]; // Cycles since each wave last changed.
	int hcnt; // Cycles spent in hold.
	int err_count = 0, checks_done = 0;
	csf_flags_t flags_o; // Flag bank seen at the outputs.

	// Clock of 100 MHz.
	always #5 clk_i = ~clk_i;

	csf_flags_top #(.HALF_1S(H1), .HALF_100MS(H2), .HALF_10MS(H3)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scan_end_i(scan_end_i),
		.preset_alter_i(preset_alter_i), .preset_clear_i(preset_clear_i),
		.download_i(download_i), .cmp_valid_i(cmp_valid_i), .cmp_a_i(cmp_a_i),
		.cmp_b_i(cmp_b_i), .catch_i(catch_i), .flags_o(flags_o), .irq_o(irq_o)
	);

	// Half period that each wave must keep.
	function automatic int half_of(input int i);
		return (i == 0) ? H1 : ((i == 1) ? H2 : H3);
	endfunction

	// ----------
	// Reference model, updated at the edge that takes the inputs.
	// ----------
	always @(posedge clk_i) begin
		if (rst_i) begin
			m = '0;
			pc = catch_i;
			lk = '0;
		end else begin
			if (preset_alter_i) begin
				m[4] = 1'b1;
			end else if (preset_clear_i || download_i) begin
				m[4] = 1'b0;
			end
			if (cmp_valid_i) begin
				m[9:7] = {cmp_a_i < cmp_b_i, cmp_a_i == cmp_b_i, cmp_a_i > cmp_b_i};
			end
			// one edge per scan; the boundary cycle belongs to the old scan
			for (int b = 0; b < 2; b++) begin
				if (catch_i[b] != pc[b] && !lk[b]) begin
					m[10+b] = catch_i[b];
					lk[b] = 1'b1;
				end
				if (scan_end_i) begin
					lk[b] = 1'b0;
				end
			end
			pc = catch_i;
		end
	end

	// Event flags are compared every cycle once settled.
	always @(negedge clk_i) begin
		if (chk_on && !rst_i) `CHK("event_flags", m & EV_MASK, flags_o & EV_MASK)
	end

	// Measures every half period of the three waves that starts at a change of level.
	always @(negedge clk_i) begin
		if (rst_i) begin
			prv = '0;
			ok = '0;
			hcnt = 0;
			cnt = '{0, 0, 0};
		end else begin
			hcnt = hold_m ? hcnt + 1 : 0;
			for (int i = 0; i < 3; i++) begin
				if (flags_o[i+1] !== prv[i]) begin
					if (ok[i]) `CHK("wave_half", half_of(i), cnt[i])
					ok[i] = 1'b1;
					cnt[i] = 1;
					prv[i] = flags_o[i+1];
				end else begin
					cnt[i]++;
				end
			end
			// A restarted wave gives no period until its first change.
			if (hold_m) begin
				ok[0] = 1'b0;
			end
			if (hcnt > 3) `CHK("hold_low", 1'b0, flags_o[1])
		end
	end

	// ----------
	// Bus and event tasks.
	// ----------
	// One classic cycle: hold until ack is seen, release at that edge.
	task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		// Ack is sampled at the rising edge; data is taken and the request dropped there.
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		`CHK("wb_ack", 1'b1, wb_ack_o)
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// Reads a register and compares the word.
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
		wb_xfer(1'b0, a, 4'hf, 32'h0);
		`CHK("wb_read", ex, q)
	endtask

	// One-cycle pulse on the chosen event input.
	task automatic ev_pulse(input int k);
		@(posedge clk_i);
		case (k)
			0: preset_alter_i <= 1'b1;
			1: preset_clear_i <= 1'b1;
			2: download_i <= 1'b1;
			3: scan_end_i <= 1'b1;
			default: cmp_valid_i <= 1'b1;
		endcase
		@(posedge clk_i);
		preset_alter_i <= 1'b0;
		preset_clear_i <= 1'b0;
		download_i <= 1'b0;
		scan_end_i <= 1'b0;
		cmp_valid_i <= 1'b0;
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic final_report();
		$display("Mismatches %0d, comparisons %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// ----------
	// Main sequence.
	// ----------
	initial begin
		void'($urandom(32'hb12e));
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		chk_on = 1'b1;
		@(negedge clk_i);
		`CHK("flags_reset", 12'h000, flags_o)
		rd_chk(OFS_CTRL, 32'h0);
		rd_chk(OFS_IRQ_MASK, 32'h0);
		rd_chk(8'h10, 32'h0);
		// Random event traffic while the program is stopped.
		repeat (400) begin
			@(posedge clk_i);
			preset_alter_i <= ($urandom % 8) == 0;
			preset_clear_i <= ($urandom % 12) == 0;
			download_i <= ($urandom % 20) == 0;
			cmp_valid_i <= ($urandom % 3) == 0;
			cmp_a_i <= 16'($urandom % 4);
			cmp_b_i <= 16'($urandom % 4);
			catch_i <= 2'($urandom % 4);
			scan_end_i <= ($urandom % 6) == 0;
		end
		ev_pulse(3);
		// The bench never writes the bank; an unmapped write and sel[0] low change nothing.
		wb_xfer(1'b1, 8'h10, 4'hf, 32'hfff);
		wb_xfer(1'b0, OFS_FLAGS, 4'hf, 32'h0);
		`CHK("flags_read", m & EV_MASK, q[11:0] & EV_MASK)
		wb_xfer(1'b1, OFS_CTRL, 4'he, 32'h7);
		rd_chk(OFS_CTRL, 32'h0);
		// Interrupt raised, masked, cleared.
		wb_xfer(1'b1, OFS_IRQ_STAT, 4'hf, 32'hf);
		rd_chk(OFS_IRQ_STAT, 32'h0);
		ev_pulse(0);
		rd_chk(OFS_IRQ_STAT, 32'h4);
		`CHK("irq_masked", 1'b0, irq_o)
		wb_xfer(1'b1, OFS_IRQ_MASK, 4'hf, 32'h4);
		wait_n(2);
		`CHK("irq_on", 1'b1, irq_o)
		ev_pulse(1);
		ev_pulse(0);
		ev_pulse(2);
		wb_xfer(1'b1, OFS_IRQ_STAT, 4'hf, 32'h4);
		wait_n(2);
		`CHK("irq_off", 1'b0, irq_o)
		ev_pulse(4);
		rd_chk(OFS_IRQ_STAT, 32'h8);
		wb_xfer(1'b1, OFS_IRQ_STAT, 4'hf, 32'hf);
		// Start pulse spans exactly the first scan.
		wb_xfer(1'b1, OFS_CTRL, 4'hf, 32'h1);
		wait_n(2);
		`CHK("start_on", 2'b11, {flags_o.run_indicator, flags_o.start_scan_pulse})
		rd_chk(OFS_IRQ_STAT, 32'h1);
		ev_pulse(3);
		wait_n(1);
		`CHK("start_off", 2'b10, {flags_o.run_indicator, flags_o.start_scan_pulse})
		ev_pulse(3);
		wait_n(1);
		`CHK("start_stays", 2'b10, {flags_o.run_indicator, flags_o.start_scan_pulse})
		wb_xfer(1'b1, OFS_CTRL, 4'hf, 32'h4);
		wait_n(2);
		`CHK("tirq_on", 2'b01, {flags_o.run_indicator, flags_o.timer_irq_enabled_flag})
		wb_xfer(1'b1, OFS_CTRL, 4'hf, 32'h0);
		wait_n(2);
		`CHK("tirq_off", 1'b0, flags_o.timer_irq_enabled_flag)
		// Hold stops the one second wave only.
		wb_xfer(1'b1, OFS_CTRL, 4'hf, 32'h2);
		hold_m = 1'b1;
		wait_n(100);
		wb_xfer(1'b1, OFS_CTRL, 4'hf, 32'h0);
		hold_m = 1'b0;
		wait_n(200);
		// A second reset clears the whole bank.
		@(posedge clk_i);
		rst_i <= 1'b1;
		wait_n(2);
		`CHK("flags_in_reset", 12'h000, flags_o)
		@(posedge clk_i);
		rst_i <= 1'b0;
		wait_n(1);
		`CHK("flags_after_reset", 12'h000, flags_o)
		rd_chk(OFS_IRQ_STAT, 32'h0);
		final_report();
	end

	// Cuts a hang short; the tests need about 800 cycles.
	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		$display("[FAIL] watchdog expected done seen timeout");
		final_report();
	end
endmodule // tb_controller_system_flags
`default_nettype wire
